// ---- hw/psq_defines.svh ----
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH
// Behaviour
// - Two-bit mode field per port, eight ports
// - Manual: one detect or classify per command
// - Manual: power on/off commands any time
// - Semi-auto: loop detection, power only on command
// - Standalone: auto power after good detection
// - Standalone valid only with strap held high
// - Shutdown: no detection, never power
// - Fault, disconnect or off command removes power
// - Any reset samples the two straps
// - Later strap changes ignored until reset, except standalone strap going low
// - Class sets trip and limit thresholds
// - Automatic thresholds only after standalone reset
// - Forced current, then forced voltage, both pass
// - Under one volt first step: short
// - Resistance bins short, low, good, high
// - Open, capacitance, voltage range, unknown codes
// - Semi-auto status refreshed every detection
// - Backoff 100ms, or 2s in midspan
// - High power semi-auto needs good, else fault
// - Detection off when disabled or shut down
// - Classify after good detect or on command

// ****************************************
// Timing
// ****************************************
`define PSQ_CLK_MHZ 100
`define PSQ_T_BACKOFF_MS 100
`define PSQ_T_BACKOFF_MID_S 2
`define PSQ_BACKOFF_CYC (`PSQ_T_BACKOFF_MS * 1000 * `PSQ_CLK_MHZ)
`define PSQ_BACKOFF_MID_CYC (`PSQ_T_BACKOFF_MID_S * 1000000 * `PSQ_CLK_MHZ)

// ****************************************
// Register offsets
// ****************************************
`define PSQ_OFS_CTRL 8'h00
`define PSQ_OFS_MODE 8'h04
`define PSQ_OFS_EN 8'h08
`define PSQ_OFS_CMD 8'h0c
`define PSQ_OFS_PWR 8'h10
`define PSQ_OFS_PSTAT 8'h20
`define PSQ_OFS_THR 8'h40
`define PSQ_POS_RST_ALL 0
`define PSQ_POS_HP_EN 1
`define PSQ_RST_THR {`PSQ_I_LIM_LO, `PSQ_I_CUT_C3}

// ****************************************
// Encodings
// ****************************************
`define PSQ_MODE_OFF 2'h0
`define PSQ_MODE_MAN 2'h1
`define PSQ_MODE_SEMI 2'h2
`define PSQ_MODE_AUTO 2'h3
`define PSQ_DET_UNKNOWN 3'h0
`define PSQ_DET_SHORT 3'h1
`define PSQ_DET_CPD_HIGH 3'h2
`define PSQ_DET_RSIG_LOW 3'h3
`define PSQ_DET_GOOD 3'h4
`define PSQ_DET_RSIG_HIGH 3'h5
`define PSQ_DET_OPEN 3'h6
`define PSQ_DET_VRANGE 3'h7
// Resistance bin edges in 100 ohm units
`define PSQ_R_SHORT 16'h0018
`define PSQ_R_LOW 16'h00aa
`define PSQ_R_HIGH 16'h0122
`define PSQ_R_OPEN 16'h01f4
// Thresholds in mA
`define PSQ_I_CUT_C1 10'h070
`define PSQ_I_CUT_C2 10'h0ce
`define PSQ_I_CUT_C3 10'h177
`define PSQ_I_CUT_C4 10'h27e
`define PSQ_I_LIM_LO 10'h1a9
`define PSQ_I_LIM_C4 10'h352
`endif

// ---- hw/psq_pkg.sv ----
package psq_pkg;
  typedef enum logic [2:0] {PSQ_IDLE, PSQ_FI, PSQ_FV, PSQ_CLS, PSQ_BO, PSQ_PWR} psq_st_t;
  // One measurement step result from the analog front end
  typedef struct packed {
    logic done;
    logic [15:0] signature_resistance;
    logic port_capacitance_high;
    logic v_over_10;
    logic v_under_1;
  } psq_meas_t;
  typedef struct packed {
    logic done;
    logic [2:0] pd_class;
  } psq_cls_t;
  typedef struct packed {
    logic [9:0] i_lim;
    logic [9:0] i_cut;
  } psq_thr_t;
endpackage : psq_pkg

// ---- hw/psq_top.sv ----
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "psq_defines.svh"
module psq_top #(
  parameter int BACKOFF_CYC = `PSQ_BACKOFF_CYC,
  parameter int BACKOFF_MID_CYC = `PSQ_BACKOFF_MID_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic standalone_strap,
  input wire logic midspan_strap,
  input wire psq_pkg::psq_meas_t [7:0] meas,
  input wire psq_pkg::psq_cls_t [7:0] cls_res,
  input wire logic [7:0] ilim_fault,
  input wire logic [7:0] disc_evt,
  output logic [7:0] port_output_pin,
  output logic [7:0] fi_req,
  output logic [7:0] fv_req,
  output logic [7:0] cls_req,
  output psq_pkg::psq_thr_t [7:0] thr
);
  import psq_pkg::*;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `PSQ_OFS_CTRL) || (a == `PSQ_OFS_MODE) || (a == `PSQ_OFS_EN) ||
              (a == `PSQ_OFS_CMD) || (a == `PSQ_OFS_PWR) ||
              (a[7:5] == 3'h1 && a[1:0] == 2'h0) || (a[7:5] == 3'h2 && a[1:0] == 2'h0);
  endfunction : reg_hit

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  function automatic logic [2:0] r_bin(input logic [15:0] r);
    if (r < `PSQ_R_SHORT) r_bin = `PSQ_DET_SHORT;
    else if (r < `PSQ_R_LOW) r_bin = `PSQ_DET_RSIG_LOW;
    else if (r <= `PSQ_R_HIGH) r_bin = `PSQ_DET_GOOD;
    else if (r <= `PSQ_R_OPEN) r_bin = `PSQ_DET_RSIG_HIGH;
    else r_bin = `PSQ_DET_OPEN;
  endfunction : r_bin

  function automatic psq_thr_t class_thr(input logic [2:0] c);
    class_thr.i_lim = `PSQ_I_LIM_LO;
    unique case (c)
      3'h1: class_thr.i_cut = `PSQ_I_CUT_C1;
      3'h2: class_thr.i_cut = `PSQ_I_CUT_C2;
      3'h4:
      begin
        class_thr.i_cut = `PSQ_I_CUT_C4;
        class_thr.i_lim = `PSQ_I_LIM_C4;
      end
      default: class_thr.i_cut = `PSQ_I_CUT_C3;
    endcase
  endfunction : class_thr

  // ****************************************
  // Strap synchronisers and sampling
  // ****************************************
  logic [2:0] auto_s_ff, mid_s_ff;
  logic srst_ff, pend_ff, auto_lat_ff, mid_lat_ff;
  logic rst, auto_ok, strap_ld;
  logic nxt_pend, nxt_auto_lat, nxt_mid_lat;

  assign rst = !aresetn || srst_ff;
  assign strap_ld = pend_ff && (auto_s_ff[2] == auto_s_ff[1]) && (mid_s_ff[2] == mid_s_ff[1]);
  assign auto_ok = auto_lat_ff && auto_s_ff[2];

  always_comb
  begin
    nxt_pend = pend_ff;
    nxt_auto_lat = auto_lat_ff;
    nxt_mid_lat = mid_lat_ff;
    if (strap_ld)
    begin
      nxt_pend = 1'b0;
      nxt_auto_lat = auto_s_ff[2];
      nxt_mid_lat = mid_s_ff[2];
    end
  end

  always_ff @(posedge aclk)
  begin
    auto_s_ff <= {auto_s_ff[1:0], standalone_strap};
    mid_s_ff <= {mid_s_ff[1:0], midspan_strap};
    if (rst)
    begin
      pend_ff <= 1'b1;
      auto_lat_ff <= 1'b0;
      mid_lat_ff <= 1'b0;
    end
    else
    begin
      pend_ff <= nxt_pend;
      auto_lat_ff <= nxt_auto_lat;
      mid_lat_ff <= nxt_mid_lat;
    end
  end

  // ****************************************
  // AXI4-Lite slave and register file
  // ****************************************
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid, nxt_srst;
  logic [1:0] nxt_bresp, nxt_rresp;
  logic [31:0] nxt_rdata;
  logic [15:0] mode_ff, nxt_mode;
  logic [23:0] en_ff, nxt_en;
  logic hp_ff, nxt_hp;
  logic [7:0] tsf_ff, nxt_tsf;
  logic [31:0] cmd_ff, nxt_cmd;
  logic wr_en, rd_en;
  logic [31:0] wm;
  logic [7:0] thr_wr, tsf_set;
  logic [2:0] det_v [8];
  logic [2:0] cls_v [8];

  assign wr_en = awready_ff && s_axi_awvalid && wready_ff && s_axi_wvalid;
  assign rd_en = arready_ff && s_axi_arvalid;
  assign wm = strb_mask(s_axi_wstrb);

  always_comb
  begin
    nxt_awready = 1'b0;
    nxt_wready = 1'b0;
    nxt_arready = 1'b0;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_mode = mode_ff;
    nxt_en = en_ff;
    nxt_hp = hp_ff;
    nxt_cmd = 32'h0000_0000;
    nxt_srst = 1'b0;
    nxt_tsf = tsf_ff | tsf_set;
    thr_wr = 8'h00;
    if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
    if (!awready_ff && !bvalid_ff && s_axi_awvalid && s_axi_wvalid)
    begin
      nxt_awready = 1'b1;
      nxt_wready = 1'b1;
    end
    if (wr_en)
    begin
      nxt_bvalid = 1'b1;
      nxt_bresp = reg_hit(s_axi_awaddr) ? 2'h0 : 2'h2;
      unique case (1'b1)
        s_axi_awaddr == `PSQ_OFS_CTRL:
        begin
          nxt_srst = s_axi_wdata[`PSQ_POS_RST_ALL] && s_axi_wstrb[0];
          if (s_axi_wstrb[0])
            nxt_hp = s_axi_wdata[`PSQ_POS_HP_EN];
        end
        s_axi_awaddr == `PSQ_OFS_MODE:
          nxt_mode = (mode_ff & ~wm[15:0]) | (s_axi_wdata[15:0] & wm[15:0]);
        s_axi_awaddr == `PSQ_OFS_EN:
          nxt_en = (en_ff & ~wm[23:0]) | (s_axi_wdata[23:0] & wm[23:0]);
        s_axi_awaddr == `PSQ_OFS_CMD:
          nxt_cmd = s_axi_wdata & wm;
        s_axi_awaddr == `PSQ_OFS_PWR:
          nxt_tsf = tsf_set | (tsf_ff & ~(s_axi_wdata[15:8] & wm[15:8]));
        s_axi_awaddr[7:5] == 3'h2 && s_axi_awaddr[1:0] == 2'h0:
          thr_wr[s_axi_awaddr[4:2]] = 1'b1;
        default:
        begin
        end
      endcase
    end
    if (strap_ld)
    begin
      nxt_mode = auto_s_ff[2] ? 16'hffff : 16'h0000;
      nxt_en = auto_s_ff[2] ? 24'hff_ffff : 24'h00_0000;
    end
    if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
    if (!arready_ff && !rvalid_ff && s_axi_arvalid)
      nxt_arready = 1'b1;
    if (rd_en)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = reg_hit(s_axi_araddr) ? 2'h0 : 2'h2;
      nxt_rdata = 32'h0000_0000;
      unique case (1'b1)
        s_axi_araddr == `PSQ_OFS_CTRL: nxt_rdata[`PSQ_POS_HP_EN] = hp_ff;
        s_axi_araddr == `PSQ_OFS_MODE: nxt_rdata[15:0] = mode_ff;
        s_axi_araddr == `PSQ_OFS_EN: nxt_rdata[23:0] = en_ff;
        s_axi_araddr == `PSQ_OFS_PWR:
          nxt_rdata[17:0] = {mid_lat_ff, auto_lat_ff, tsf_ff, port_output_pin};
        s_axi_araddr[7:5] == 3'h1 && s_axi_araddr[1:0] == 2'h0:
          nxt_rdata[6:0] = {cls_v[s_axi_araddr[4:2]], 1'b0, det_v[s_axi_araddr[4:2]]};
        s_axi_araddr[7:5] == 3'h2 && s_axi_araddr[1:0] == 2'h0:
          nxt_rdata[25:0] = {thr[s_axi_araddr[4:2]].i_lim, 6'h00,
                             thr[s_axi_araddr[4:2]].i_cut};
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0000_0000;
      srst_ff <= 1'b0;
    end
    else
    begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      srst_ff <= nxt_srst;
    end
    if (rst)
    begin
      mode_ff <= 16'h0000;
      en_ff <= 24'h00_0000;
      hp_ff <= 1'b0;
      tsf_ff <= 8'h00;
      cmd_ff <= 32'h0000_0000;
    end
    else
    begin
      mode_ff <= nxt_mode;
      en_ff <= nxt_en;
      hp_ff <= nxt_hp;
      tsf_ff <= nxt_tsf;
      cmd_ff <= nxt_cmd;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // ****************************************
  // Per-port sequencers
  // ****************************************
  for (genvar p = 0; p < 8; p++)
  begin : g_port
    psq_st_t st_ff, nxt_st;
    logic [2:0] det_ff, nxt_det, cls_ff, nxt_cls, code;
    logic [27:0] bo_ff, nxt_bo;
    psq_thr_t thr_ff, nxt_thr;
    logic pwr_ff, fi_ff, fv_ff, cr_ff;
    logic [1:0] m;
    logic man, semi, auto_m, off, t_set;

    always_comb
    begin
      m = mode_ff[2*p +: 2];
      man = m == `PSQ_MODE_MAN;
      semi = m == `PSQ_MODE_SEMI;
      auto_m = (m == `PSQ_MODE_AUTO) && auto_ok;
      off = !(man || semi || auto_m);
      code = meas[p].v_under_1 ? `PSQ_DET_SHORT :
             meas[p].v_over_10 ? `PSQ_DET_VRANGE :
             meas[p].port_capacitance_high ? `PSQ_DET_CPD_HIGH :
             r_bin(meas[p].signature_resistance);
      nxt_st = st_ff;
      nxt_det = det_ff;
      nxt_cls = cls_ff;
      nxt_bo = bo_ff;
      nxt_thr = thr_ff;
      t_set = 1'b0;
      if (thr_wr[p])
      begin
        nxt_thr.i_cut = s_axi_wdata[9:0];
        nxt_thr.i_lim = s_axi_wdata[25:16];
      end
      unique case (st_ff)
        PSQ_IDLE:
          if (man && cmd_ff[p] && en_ff[p])
            nxt_st = PSQ_FI;
          else if (man && cmd_ff[8+p] && en_ff[8+p])
            nxt_st = PSQ_CLS;
          else if ((semi || auto_m) && en_ff[p])
            nxt_st = PSQ_FI;
        PSQ_FI:
          if (meas[p].done)
          begin
            if (code == `PSQ_DET_GOOD)
              nxt_st = PSQ_FV;
            else
            begin
              nxt_det = code;
              nxt_st = PSQ_IDLE;
            end
          end
        PSQ_FV:
          if (meas[p].done)
          begin
            nxt_det = code;
            if (code != `PSQ_DET_GOOD || man)
              nxt_st = PSQ_IDLE;
            else if (en_ff[8+p])
              nxt_st = PSQ_CLS;
            else if (auto_m)
            begin
              nxt_st = PSQ_PWR;
              nxt_thr = class_thr(3'h0);
            end
            else
            begin
              nxt_st = PSQ_BO;
              nxt_bo = mid_lat_ff ? 28'(BACKOFF_MID_CYC - 1) : 28'(BACKOFF_CYC - 1);
            end
          end
        PSQ_CLS:
          if (cls_res[p].done)
          begin
            nxt_cls = cls_res[p].pd_class;
            if (man)
              nxt_st = PSQ_IDLE;
            else if (auto_m)
            begin
              nxt_st = PSQ_PWR;
              nxt_thr = class_thr(cls_res[p].pd_class);
            end
            else
            begin
              nxt_st = PSQ_BO;
              nxt_bo = mid_lat_ff ? 28'(BACKOFF_MID_CYC - 1) : 28'(BACKOFF_CYC - 1);
            end
          end
        PSQ_BO:
          if (bo_ff == 28'h000_0000)
            nxt_st = PSQ_IDLE;
          else
            nxt_bo = bo_ff - 28'h000_0001;
        PSQ_PWR:
          if (ilim_fault[p] || (disc_evt[p] && en_ff[16+p]) || cmd_ff[24+p])
            nxt_st = PSQ_IDLE;
      endcase
      if (st_ff != PSQ_PWR && cmd_ff[16+p] && (man || semi || auto_m))
      begin
        if (semi && hp_ff && det_ff != `PSQ_DET_GOOD)
          t_set = 1'b1;
        else
          nxt_st = PSQ_PWR;
      end
      if (off)
        nxt_st = PSQ_IDLE;
    end

    always_ff @(posedge aclk)
    begin
      if (rst)
      begin
        st_ff <= PSQ_IDLE;
        det_ff <= `PSQ_DET_UNKNOWN;
        cls_ff <= 3'h0;
        bo_ff <= 28'h000_0000;
        thr_ff <= `PSQ_RST_THR;
        pwr_ff <= 1'b0;
        fi_ff <= 1'b0;
        fv_ff <= 1'b0;
        cr_ff <= 1'b0;
      end
      else
      begin
        st_ff <= nxt_st;
        det_ff <= nxt_det;
        cls_ff <= nxt_cls;
        bo_ff <= nxt_bo;
        thr_ff <= nxt_thr;
        pwr_ff <= nxt_st == PSQ_PWR;
        fi_ff <= nxt_st == PSQ_FI;
        fv_ff <= nxt_st == PSQ_FV;
        cr_ff <= nxt_st == PSQ_CLS;
      end
    end

    assign tsf_set[p] = t_set;
    assign det_v[p] = det_ff;
    assign cls_v[p] = cls_ff;
    assign port_output_pin[p] = pwr_ff;
    assign fi_req[p] = fi_ff;
    assign fv_req[p] = fv_ff;
    assign cls_req[p] = cr_ff;
    assign thr[p] = thr_ff;
  end
endmodule : psq_top
`default_nettype wire

// ---- verif/psq_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module psq_chk #(
  parameter int BACKOFF_CYC = 20,
  parameter int BACKOFF_MID_CYC = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire psq_pkg::psq_meas_t [7:0] meas,
  input wire logic [7:0] ilim_fault,
  input wire logic [7:0] port_output_pin,
  input wire logic [7:0] fi_req,
  input wire logic [7:0] fv_req,
  input wire logic [7:0] cls_req,
  input wire psq_pkg::psq_thr_t [7:0] thr
);
  import psq_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_RESET_QUIET: assert property (disable iff (1'h0)
    !aresetn |=> port_output_pin == 8'h00 && fi_req == 8'h00 && thr == {8{10'h1a9, 10'h177}})
    else $error("outputs not cleared by reset");
  for (genvar p = 0; p < 8; p++)
  begin : g_port
    AST_FAULT_OFF: assert property (
      ilim_fault[p] |-> ##[1:2] !port_output_pin[p]) else $error("power kept after fault");
    AST_REQ_EXCL: assert property (
      $onehot0({fi_req[p], fv_req[p], cls_req[p]})) else $error("two step requests at once");
    AST_FV_AFTER_FI: assert property (
      $rose(fv_req[p]) |-> $past(fi_req[p])) else $error("forced voltage without current step");
    AST_BAD_FI_NO_FV: assert property (
      fi_req[p] && meas[p].done && (meas[p].v_under_1 || meas[p].signature_resistance < 16'h00aa
      || meas[p].signature_resistance > 16'h0122) |=> !fv_req[p] [*3])
      else $error("voltage step after failed current step");
    AST_FV_DROP: assert property (
      fv_req[p] && meas[p].done |=> !fv_req[p]) else $error("voltage step held after done");
    AST_GOOD_NO_REDO: assert property (
      fv_req[p] && meas[p].done && !meas[p].v_under_1 && !meas[p].v_over_10
      && !meas[p].port_capacitance_high && meas[p].signature_resistance >= 16'h00aa
      && meas[p].signature_resistance <= 16'h0122 |=> !fi_req[p] [*2])
      else $error("detection redone after good result");
    AST_BACKOFF: assert property (
      $fell(cls_req[p]) && !port_output_pin[p] |-> !fi_req[p] [*8])
      else $error("detection repeated without backoff");
  end
  cover property ($rose(port_output_pin[0]));
  cover property ($rose(fv_req[1]));
  cover property ($fell(cls_req[1]));
endmodule : psq_chk
bind psq_top psq_chk #(.BACKOFF_CYC(BACKOFF_CYC), .BACKOFF_MID_CYC(BACKOFF_MID_CYC)) u_chk (
  .aclk, .aresetn, .meas, .ilim_fault, .port_output_pin, .fi_req, .fv_req, .cls_req, .thr);
`default_nettype wire

// ---- verif/psq_pd_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module psq_pd_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] fi_req,
  input wire logic [7:0] fv_req,
  input wire logic [7:0] cls_req,
  input wire logic [15:0] pd_res,
  input wire logic [2:0] pd_flags,
  input wire logic [23:0] pd_cls,
  input wire logic [3:0] pd_dly,
  output var psq_pkg::psq_meas_t [7:0] meas,
  output var psq_pkg::psq_cls_t [7:0] cls_res
);
  import psq_pkg::*;
  logic [7:0] done_ff;
  logic [3:0] cnt_ff [8];
  always_ff @(posedge aclk)
  begin
    for (int p = 0; p < 8; p++)
    begin
      done_ff[p] <= 1'h0;
      if (!aresetn || !(fi_req[p] | fv_req[p] | cls_req[p]) || done_ff[p])
        cnt_ff[p] <= 4'h0;
      else if (cnt_ff[p] == pd_dly)
        done_ff[p] <= 1'h1;
      else
        cnt_ff[p] <= cnt_ff[p] + 4'h1;
    end
  end
  // Outside a done cycle the results read as inverted junk
  always_comb
  begin
    for (int p = 0; p < 8; p++)
    begin
      meas[p].done = done_ff[p] & (fi_req[p] | fv_req[p]);
      {meas[p].signature_resistance, meas[p].port_capacitance_high, meas[p].v_over_10,
        meas[p].v_under_1} = meas[p].done ? {pd_res, pd_flags} : ~{pd_res, pd_flags};
      cls_res[p].done = done_ff[p] & cls_req[p];
      cls_res[p].pd_class = cls_res[p].done ? pd_cls[3*p+:3] : ~pd_cls[3*p+:3];
    end
  end
endmodule : psq_pd_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psq_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, fv_seen;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic standalone_strap = 1'h0, midspan_strap = 1'h0;
  psq_meas_t [7:0] meas;
  psq_cls_t [7:0] cls_res;
  psq_thr_t [7:0] thr;
  logic [7:0] ilim_fault = 8'h00, disc_evt = 8'h00, port_output_pin, fi_req, fv_req, cls_req;
  logic [15:0] pd_res = 16'h00c8;
  logic [2:0] pd_flags = 3'h0;
  logic [23:0] pd_cls = 24'h00_0000;
  logic [3:0] pd_dly = 4'h2;
  int errors = 0, n_tests = 0, cyc = 0;
  psq_top #(.BACKOFF_CYC(20), .BACKOFF_MID_CYC(40)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standalone_strap, .midspan_strap,
    .meas, .cls_res, .ilim_fault, .disc_evt, .port_output_pin, .fi_req, .fv_req, .cls_req, .thr);
  psq_pd_model pd (.aclk, .aresetn, .fi_req, .fv_req, .cls_req, .pd_res, .pd_flags, .pd_cls,
    .pd_dly, .meas, .cls_res);
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic got;
    got = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!got)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1)
        s_axi_wvalid <= 1'h0;
      got = (s_axi_bvalid === 1'h1);
      rsp = s_axi_bresp;
    end
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic got;
    got = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!got)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1)
        s_axi_arvalid <= 1'h0;
      got = (s_axi_rvalid === 1'h1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
    end
    s_axi_rready <= 1'h0;
  endtask : rdr
  task automatic wait_bit(input string nm, ref logic [7:0] v, input int b, input logic e);
    int k;
    k = 0;
    while (v[b] !== e && k < 300)
    begin
      @(posedge aclk);
      k++;
    end
    chk(nm, e, v[b]);
  endtask : wait_bit
  task automatic wait_idle(input int p);
    int k;
    k = 0;
    fv_seen = 1'h0;
    wait_bit("step start", fi_req, p, 1'h1);
    while ((fi_req[p] | fv_req[p] | cls_req[p]) !== 1'h0 && k < 300)
    begin
      @(posedge aclk);
      fv_seen = fv_seen | fv_req[p];
      k++;
    end
  endtask : wait_idle
  task automatic do_reset(input logic s, input logic m);
    @(posedge aclk);
    aresetn <= 1'h0;
    standalone_strap <= s;
    midspan_strap <= m;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
  endtask : do_reset
  function automatic psq_thr_t exp_thr(input logic [2:0] c);
    case (c)
      3'h1: return {10'h1a9, 10'h070};
      3'h2: return {10'h1a9, 10'h0ce};
      3'h4: return {10'h352, 10'h27e};
      default: return {10'h1a9, 10'h177};
    endcase
  endfunction : exp_thr
  task automatic t_reset;
    rdr(8'h20);
    chk("status", 32'h0000_0000, rd);
    rdr(8'h40);
    chk("thr reg", 32'h01a9_0177, rd);
    rdr(8'h04);
    chk("mode", 32'h0000_0000, rd);
    rdr(8'hf0);
    chk("unmapped resp", 2'h2, rsp);
    wr(8'hf0, 32'h0000_0000);
    chk("unmapped bresp", 2'h2, rsp);
    wr(8'h04, 32'h0000_00c0);
    wr(8'h08, 32'h0000_00ff);
    wr(8'h0c, 32'h0001_00ff);
    repeat (30) @(posedge aclk);
    chk("fi in shutdown", 8'h00, fi_req);
    chk("pin in shutdown", 8'h00, port_output_pin);
    $display("reset and shutdown test done");
  endtask : t_reset
  task automatic t_manual;
    logic [15:0] rv [8] = '{16'h0010, 16'h00c8, 16'h0050, 16'h00c8, 16'h0190, 16'h0258,
      16'h00c8, 16'h00c8};
    logic [2:0] fl [8] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2};
    logic [2:0] ec [8] = '{3'h1, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h2, 3'h7};
    wr(8'h04, 32'h0000_0001);
    wr(8'h08, 32'h0000_01ff);
    for (int i = 0; i < 8; i++)
    begin
      pd_res <= rv[i];
      pd_flags <= fl[i];
      pd_dly <= 4'(i);
      wr(8'h0c, 32'h0000_0001);
      wait_idle(0);
      rdr(8'h20);
      chk("detect code", ec[i], rd[2:0]);
      if (i < 6)
        chk("fv step", i == 3, fv_seen);
    end
    repeat (30) @(posedge aclk);
    chk("single detect", 1'h0, fi_req[0]);
    pd_cls <= 24'h00_0003;
    wr(8'h0c, 32'h0000_0100);
    wait_bit("class req", cls_req, 0, 1'h1);
    wait_bit("class end", cls_req, 0, 1'h0);
    rdr(8'h20);
    chk("class", 3'h3, rd[6:4]);
    chk("manual thr", {10'h1a9, 10'h177}, thr[0]);
    wr(8'h0c, 32'h0001_0000);
    wait_bit("pin on", port_output_pin, 0, 1'h1);
    wr(8'h0c, 32'h0100_0000);
    wait_bit("pin off", port_output_pin, 0, 1'h0);
    midspan_strap <= 1'h1;
    repeat (10) @(posedge aclk);
    rdr(8'h10);
    chk("late strap", 1'h0, rd[17]);
    $display("manual test done");
  endtask : t_manual
  task automatic t_semi;
    int k;
    k = 0;
    pd_res <= 16'h00c8;
    pd_flags <= 3'h0;
    pd_cls <= 24'h00_0010;
    wr(8'h04, 32'h0000_0008);
    repeat (30) @(posedge aclk);
    chk("no enable", 1'h0, fi_req[1]);
    wr(8'h08, 32'h0000_0202);
    wait_bit("semi class", cls_req, 1, 1'h1);
    wait_bit("class end", cls_req, 1, 1'h0);
    while (fi_req[1] !== 1'h1 && k < 300)
    begin
      @(posedge aclk);
      k++;
    end
    chk("midspan backoff", 1'h1, k >= 40 && k < 300);
    chk("semi no power", 1'h0, port_output_pin[1]);
    rdr(8'h24);
    chk("semi status", 32'h0000_0024, rd);
    chk("semi thr", {10'h1a9, 10'h177}, thr[1]);
    rdr(8'h10);
    chk("mid latch", 1'h1, rd[17]);
    wr(8'h0c, 32'h0002_0000);
    wait_bit("semi power", port_output_pin, 1, 1'h1);
    ilim_fault <= 8'h02;
    @(posedge aclk);
    ilim_fault <= 8'h00;
    wait_bit("fault off", port_output_pin, 1, 1'h0);
    pd_res <= 16'h0050;
    wr(8'h00, 32'h0000_0002);
    wr(8'h04, 32'h0000_0028);
    wr(8'h08, 32'h0000_0606);
    repeat (40) @(posedge aclk);
    rdr(8'h28);
    chk("low code", 3'h3, rd[2:0]);
    wr(8'h0c, 32'h0004_0000);
    repeat (10) @(posedge aclk);
    chk("hp refuse", 1'h0, port_output_pin[2]);
    rdr(8'h10);
    chk("start fault", 1'h1, rd[10]);
    wr(8'h04, 32'h0000_0018);
    wr(8'h0c, 32'h0004_0000);
    wait_bit("forced on", port_output_pin, 2, 1'h1);
    wr(8'h00, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk("reset all pin", 8'h00, port_output_pin);
    rdr(8'h28);
    chk("reset all status", 32'h0000_0000, rd);
    $display("semi test done");
  endtask : t_semi
  task automatic t_auto;
    int k;
    k = 0;
    rdr(8'h04);
    chk("auto mode", 32'h0000_ffff, rd);
    rdr(8'h08);
    chk("auto enable", 32'h00ff_ffff, rd);
    while (port_output_pin !== 8'hff && k < 300)
    begin
      @(posedge aclk);
      k++;
    end
    chk("auto power", 8'hff, port_output_pin);
    for (int p = 0; p < 8; p++)
      chk("class thr", exp_thr(pd_cls[3*p+:3]), thr[p]);
    disc_evt <= 8'h01;
    @(posedge aclk);
    disc_evt <= 8'h00;
    wait_bit("disconnect", port_output_pin, 0, 1'h0);
    $display("standalone test done");
  endtask : t_auto
  initial
  begin
    do_reset(1'h0, 1'h0);
    t_reset();
    t_manual();
    do_reset(1'h0, 1'h1);
    t_semi();
    pd_res <= 16'h00c8;
    pd_cls <= 24'h88_c0d1;
    do_reset(1'h1, 1'h0);
    t_auto();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
